// ==== src/gxi_pkg.sv ====
package gxi_pkg;

  // Register offsets on the serial bus.
  localparam logic [7:0] GXI_REG_IN0 = 8'h00;
  localparam logic [7:0] GXI_REG_IN1 = 8'h01;
  localparam logic [7:0] GXI_REG_CFG0 = 8'h08;
  localparam logic [7:0] GXI_REG_CFG1 = 8'h09;
  localparam logic [7:0] GXI_REG_MASK0 = 8'h0C;
  localparam logic [7:0] GXI_REG_MASK1 = 8'h0D;
  localparam logic [7:0] GXI_REG_SRC0 = 8'h0E;
  localparam logic [7:0] GXI_REG_SRC1 = 8'h0F;

  // Reset values.
  localparam logic [7:0] GXI_CFG_RST = 8'hFF;
  localparam logic [7:0] GXI_MASK_RST = 8'hFF;
  localparam logic [7:0] GXI_SRC_RST = 8'h00;
  localparam logic [7:0] GXI_ZERO_BYTE = 8'h00;

  // Bus addressing; the device address value is arbitrary.
  localparam logic [6:0] GXI_DEV_ADDR = 7'h20;
  localparam logic [7:0] GXI_GC_ADDR = 8'h00;
  localparam logic [7:0] GXI_SWRST_BYTE = 8'h06;

  // Bit counter marks: eight data bits, then the acknowledge clock.
  localparam logic [3:0] GXI_BYTE_BITS = 4'h8;
  localparam logic [3:0] GXI_ACK_DONE = 4'h9;

  typedef struct packed {
    logic [7:0] p1;
    logic [7:0] p0;
  } gxi_pair_t;

  typedef enum logic [2:0] {
    GXI_IDLE,
    GXI_ADDR,
    GXI_PTR,
    GXI_WDATA,
    GXI_RDATA,
    GXI_GC,
    GXI_GC_ARMED,
    GXI_SKIP
  } gxi_state_t;

endpackage

// ==== src/gxi_top.sv ====
// How it works
// R1 - Port 1 mask resets to all ones.
// R2 - Mask bit zero enables, one disables.
// R3 - Status registers read-only, default zero.
// R4 - Masked port status reads all zero.
// R5 - Power-on reset loads every default.
// R6 - Reset pin low holds all defaults.
// R7 - Acknowledge general call write, refuse read.
// R8 - Acknowledge reset byte 06h only.
// R9 - Refuse every byte after the first.
// R10 - STOP resets; repeated START cancels it.
// R11 - Master treats any refusal as abort.
// R12 - Unmasked input change asserts interrupt low.
// R13 - Interrupt drops on return or read.
// R14 - Only matching input read clears condition.
// R15 - Output-to-input switch may raise interrupt.
// R16 - Master programs mask, direction at start.
// R17 - Standby while bus idle.
// R18 - SDA steady while SCL high.
// R19 - START and STOP from SDA edges.
// R20 - Acknowledge every received byte low.
// R21 - Release SDA after master refuses.
// R22 - Single byte writes and reads.
// R23 - Direction one is input, default input.
// R24 - Status bit marks unmasked causing input.
`timescale 1ns/1ps
`default_nettype none

module gxi_top
  import gxi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_n,
  input wire logic reset_pin_n,
  input wire logic [15:0] gpio_i,
  output logic int_oe_n,
  output logic standby,
  output logic [15:0] dir_is_input
);

  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic [1:0] rpin_s_q;
  logic scl_d_q;
  logic sda_d_q;
  gxi_pair_t pin_s1_q;
  gxi_pair_t pin_s2_q;

  gxi_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] tx_q;
  logic [7:0] wr_data_q;
  logic mack_q;
  logic sw_rst_q;
  logic wr_q;
  logic [1:0] rd_in_q;
  logic sda_oe_n_q;

  gxi_pair_t cfg_q;
  gxi_pair_t mask_q;
  gxi_pair_t snap_q;
  logic init_q;
  gxi_pair_t src;

  logic int_oe_n_q;
  logic standby_q;

  logic scl_h;
  logic sda_h;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic clr;
  logic [7:0] rd_byte;

  function automatic logic [7:0] rd_mux(
    input logic [7:0] idx,
    input gxi_pair_t pins,
    input gxi_pair_t cfg,
    input gxi_pair_t mask,
    input gxi_pair_t srcv
  );
    logic [7:0] r;
    r = GXI_ZERO_BYTE;
    unique case (idx)
      GXI_REG_IN0: r = pins.p0;
      GXI_REG_IN1: r = pins.p1;
      GXI_REG_CFG0: r = cfg.p0;
      GXI_REG_CFG1: r = cfg.p1;
      GXI_REG_MASK0: r = mask.p0;
      GXI_REG_MASK1: r = mask.p1;
      GXI_REG_SRC0: r = srcv.p0;
      GXI_REG_SRC1: r = srcv.p1;
      default: r = GXI_ZERO_BYTE;
    endcase
    return r;
  endfunction

  // Default image of a register pair after any kind of reset.
  function automatic gxi_pair_t rst_pair(input logic [7:0] v);
    gxi_pair_t r;
    r.p1 = v;
    r.p0 = v;
    return r;
  endfunction

  // Every pin from outside passes two flip-flops before it is used.
  // The reset pin's chain clears to low, so the core keeps its defaults for two
  // more cycles after rst. That lines it up with the gpio chain, whose zeros
  // would otherwise be taken as the first report and then seen as a change.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      rpin_s_q <= 2'h0;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      rpin_s_q <= {rpin_s_q[0], reset_pin_n};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
      pin_s1_q <= gpio_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign scl_h = scl_s_q[1];
  assign sda_h = sda_s_q[1];
  assign scl_rise = scl_h & ~scl_d_q;
  assign scl_fall = ~scl_h & scl_d_q;
  // An SDA edge with SCL high is a control condition, never data. [R18]
  assign bus_start = scl_h & scl_d_q & sda_d_q & ~sda_h; // [R19]
  assign bus_stop = scl_h & scl_d_q & ~sda_d_q & sda_h; // [R19]
  // Pin reset and software reset share one path, so both give the same
  // defaults as power-on reset.
  assign clr = sw_rst_q | ~rpin_s_q[1]; // [R6] [R10]
  assign rd_byte = rd_mux(ptr_q, pin_s2_q, cfg_q, mask_q, src);

  // Serial bus slave.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin // [R5]
      state_q <= GXI_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      wr_data_q <= 8'h00;
      mack_q <= 1'b0;
      sw_rst_q <= 1'b0;
      wr_q <= 1'b0;
      rd_in_q <= 2'h0;
      sda_oe_n_q <= 1'b1;
    end else begin
      sw_rst_q <= 1'b0;
      wr_q <= 1'b0;
      rd_in_q <= 2'h0;
      if (clr) begin // [R6]
        state_q <= GXI_IDLE;
        cnt_q <= 4'h0;
        ptr_q <= 8'h00;
        mack_q <= 1'b0;
        sda_oe_n_q <= 1'b1;
      end else if (bus_start) begin
        // A repeated START also drops an armed software reset. [R10]
        state_q <= GXI_ADDR;
        cnt_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end else if (bus_stop) begin
        state_q <= GXI_IDLE;
        cnt_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
        // The STOP needs one SCL rise of its own after the reset byte's
        // acknowledge, and that rise has already been counted as a bit. Any
        // more rises would belong to a second byte, which cancels the reset.
        if (state_q == GXI_GC_ARMED && cnt_q <= 4'h1) begin
          sw_rst_q <= 1'b1; // [R10]
        end
      end else if (scl_rise && state_q != GXI_IDLE) begin
        if (cnt_q < GXI_BYTE_BITS) begin
          shift_q <= {shift_q[6:0], sda_h};
        end
        if (cnt_q == GXI_BYTE_BITS && state_q == GXI_RDATA) begin
          mack_q <= ~sda_h;
        end
        if (cnt_q < GXI_ACK_DONE) begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (scl_fall && state_q != GXI_IDLE) begin
        if (cnt_q == GXI_BYTE_BITS) begin
          unique case (state_q)
            GXI_ADDR: begin
              if (shift_q[7:1] == GXI_DEV_ADDR) begin
                sda_oe_n_q <= 1'b0; // [R20]
                mack_q <= 1'b1;
                state_q <= shift_q[0] ? GXI_RDATA : GXI_PTR;
              end else if (shift_q == GXI_GC_ADDR) begin
                sda_oe_n_q <= 1'b0; // [R7]
                state_q <= GXI_GC;
              end else begin
                // This also catches a general call read, 01h.
                state_q <= GXI_SKIP; // [R7]
              end
            end
            GXI_PTR: begin
              sda_oe_n_q <= 1'b0; // [R20]
              ptr_q <= shift_q;
              state_q <= GXI_WDATA;
            end
            GXI_WDATA: begin
              sda_oe_n_q <= 1'b0; // [R20] [R22]
              wr_data_q <= shift_q;
              wr_q <= 1'b1;
            end
            GXI_GC: begin
              if (shift_q == GXI_SWRST_BYTE) begin
                sda_oe_n_q <= 1'b0; // [R8]
                state_q <= GXI_GC_ARMED;
              end else begin
                state_q <= GXI_SKIP; // [R8]
              end
            end
            GXI_GC_ARMED: state_q <= GXI_SKIP; // [R9]
            GXI_RDATA: sda_oe_n_q <= 1'b1;
            GXI_IDLE, GXI_SKIP: sda_oe_n_q <= 1'b1;
          endcase
        end else if (cnt_q == GXI_ACK_DONE) begin
          cnt_q <= 4'h0;
          sda_oe_n_q <= 1'b1;
          // The first data bit goes out at the fall that ends the acknowledge
          // clock, so it is settled long before the master's next rise.
          if (state_q == GXI_RDATA) begin
            if (mack_q) begin
              tx_q <= rd_byte;
              sda_oe_n_q <= rd_byte[7];
              // A read of an input register marks its port as seen. [R14]
              rd_in_q <= {ptr_q == GXI_REG_IN1, ptr_q == GXI_REG_IN0};
            end else begin
              state_q <= GXI_SKIP; // [R21]
            end
          end
        end else if (state_q == GXI_RDATA && cnt_q != 4'h0) begin
          tx_q <= {tx_q[6:0], 1'b0};
          sda_oe_n_q <= tx_q[6];
        end
      end
    end
  end

  // Direction and mask registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin // [R1] [R23] [R5]
      cfg_q <= rst_pair(GXI_CFG_RST);
      mask_q <= rst_pair(GXI_MASK_RST);
    end else if (clr) begin // [R1] [R6]
      cfg_q <= rst_pair(GXI_CFG_RST);
      mask_q <= rst_pair(GXI_MASK_RST);
    end else if (wr_q) begin // [R2] [R22]
      unique case (ptr_q)
        GXI_REG_CFG0: cfg_q.p0 <= wr_data_q;
        GXI_REG_CFG1: cfg_q.p1 <= wr_data_q;
        GXI_REG_MASK0: mask_q.p0 <= wr_data_q;
        GXI_REG_MASK1: mask_q.p1 <= wr_data_q;
        // Read-only and unmapped offsets land here and change nothing.
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Last reported input levels; pin changes are judged against these.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      snap_q <= '0;
      init_q <= 1'b0;
    end else if (clr) begin
      init_q <= 1'b0;
    end else if (!init_q) begin
      snap_q <= pin_s2_q;
      init_q <= 1'b1;
    end else begin
      if (rd_in_q[0]) begin
        snap_q.p0 <= tx_q; // [R13] [R14]
      end
      if (rd_in_q[1]) begin
        snap_q.p1 <= tx_q; // [R13] [R14]
      end
    end
  end

  // An unmasked input pin whose level differs from the last report is a source, so a return
  // to that level clears it without a read. Switching a pin to input with a
  // stale report raises a source too; that is the device's known behaviour.
  // Per-port views of the pairs, so that both ports share one loop body.
  logic [1:0][7:0] pin_v;
  logic [1:0][7:0] snap_v;
  logic [1:0][7:0] cfg_v;
  logic [1:0][7:0] mask_v;
  logic [1:0][7:0] src_v;

  assign pin_v = pin_s2_q;
  assign snap_v = snap_q;
  assign cfg_v = cfg_q;
  assign mask_v = mask_q;
  assign src = src_v;

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign src_v[p] = init_q ? ((pin_v[p] ^ snap_v[p]) & cfg_v[p] & ~mask_v[p]) // [R4] [R24]
      : GXI_SRC_RST; // [R3] [R15]
  end

  // Interrupt pin: pulled low while any port has a source.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_oe_n_q <= 1'b1;
    end else begin
      int_oe_n_q <= ~(|src); // [R12] [R13]
    end
  end

  // Standby drops on the first low level of either line and returns one cycle
  // after the bus is seen idle again; it gates nothing inside the block.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= (state_q == GXI_IDLE) & scl_h & sda_h; // [R17]
    end
  end

  assign sda_oe_n = sda_oe_n_q;
  assign int_oe_n = int_oe_n_q;
  assign standby = standby_q;
  assign dir_is_input = cfg_q; // [R23]

endmodule

`default_nettype wire

// ==== testbench/gxi_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module gxi_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  localparam realtime Q = 31.25;
  // Both lines idle high and SCL moves only inside a frame.
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Entered idle or with SCL low, so it also serves as repeated START.
  task automatic start();
    sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #(4 * Q);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // Single-byte reads only, so the byte is always refused.
  task automatic get(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(1'b1, r);
  endtask
endmodule
`default_nettype wire

// ==== testbench/gxi_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module gxi_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_n,
  input wire logic reset_pin_n,
  input wire logic int_oe_n,
  input wire logic standby,
  input wire logic [15:0] dir_is_input
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_scl_low; !scl_i [*5]; endsequence
  sequence s_pin_low; !reset_pin_n [*5]; endsequence
  sequence s_rst_two; rst ##1 rst; endsequence
  property p_drv_on; $fell(sda_oe_n) |-> !scl_i; endproperty
  a_drv_on: assert property (p_drv_on) else $error("sda pulled with scl high");
  property p_drv_off; $rose(sda_oe_n) |-> !scl_i; endproperty
  a_drv_off: assert property (p_drv_off) else $error("sda freed with scl high");
  property p_ack_hold; $fell(sda_oe_n) |=> !sda_oe_n [*7]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda drive too short");
  property p_sby; s_scl_low |-> !standby; endproperty
  a_sby: assert property (p_sby) else $error("standby during clocking");
  property p_sby_drv; !sda_oe_n |-> !standby; endproperty
  a_sby_drv: assert property (p_sby_drv) else $error("standby while driving");
  property p_idle; $rose(standby) |-> scl_i && sda_i; endproperty
  a_idle: assert property (p_idle) else $error("standby with bus busy");
  property p_rst;
    disable iff (1'b0) s_rst_two |-> dir_is_input == 16'hFFFF && int_oe_n && sda_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset defaults wrong");
  property p_pin; s_pin_low |-> dir_is_input == 16'hFFFF && int_oe_n; endproperty
  a_pin: assert property (p_pin) else $error("pin reset defaults wrong");
endmodule
`default_nettype wire

// ==== testbench/gxi_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module gxi_top_bench
  import gxi_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic [15:0] gpio_i = 16'h0000;
  wire logic scl_i;
  wire logic sda_m;
  wire logic sda_oe_n;
  wire logic int_oe_n;
  wire logic standby;
  wire logic [15:0] dir_is_input;
  // SDA has a pull-up, so it is low only while someone pulls it.
  wire logic sda_i = sda_m & sda_oe_n;
  int num_errors = 0;
  int tests_run = 0;
  gxi_top gxi_top_inst (.core_clk, .rst, .scl_i, .sda_i, .sda_oe_n, .reset_pin_n, .gpio_i,
    .int_oe_n, .standby, .dir_is_input);
  gxi_master gxi_master_inst (.scl(scl_i), .sda_m, .sda(sda_i));
  initial forever #5 core_clk = ~core_clk;
  task automatic print_verdict();
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tx(input logic [7:0] b, input logic e);
    logic k;
    gxi_master_inst.put(b, k);
    `CHK("ack", e, k)
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    gxi_master_inst.start();
    tx({GXI_DEV_ADDR, 1'b0}, 1'b1);
    tx(p, 1'b1);
    tx(v, 1'b1);
    gxi_master_inst.stop();
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    gxi_master_inst.start();
    tx({GXI_DEV_ADDR, 1'b0}, 1'b1);
    tx(p, 1'b1);
    gxi_master_inst.start();
    tx({GXI_DEV_ADDR, 1'b1}, 1'b1);
    gxi_master_inst.get(d);
    gxi_master_inst.stop();
    `CHK("reg", e, d)
  endtask
  task automatic pin(input int b, input logic v, input logic e);
    @(posedge core_clk);
    gpio_i[b] <= v;
    repeat (8) @(negedge core_clk);
    `CHK("int", e, int_oe_n)
  endtask
  task automatic gc(input logic [7:0] b, input logic e);
    gxi_master_inst.start();
    tx(GXI_GC_ADDR, 1'b1);
    tx(b, e);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
  end
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
  initial begin
    @(negedge rst);
    repeat (8) @(negedge core_clk);
    rd(GXI_REG_MASK1, GXI_MASK_RST);
    `CHK("standby", 1'b1, standby)
    wr(GXI_REG_SRC1, 8'hFF);
    rd(GXI_REG_SRC1, GXI_SRC_RST);
    wr(GXI_REG_MASK1, 8'hFE);
    rd(GXI_REG_MASK1, 8'hFE);
    rd(GXI_REG_IN1, 8'h00);
    pin(9, 1'b1, 1'b1);
    pin(0, 1'b1, 1'b1);
    pin(8, 1'b1, 1'b0);
    rd(GXI_REG_SRC1, 8'h01);
    rd(GXI_REG_SRC0, 8'h00);
    rd(GXI_REG_IN0, 8'h01);
    `CHK("int", 1'b0, int_oe_n)
    rd(GXI_REG_IN1, 8'h03);
    `CHK("int", 1'b1, int_oe_n)
    pin(8, 1'b0, 1'b0);
    pin(8, 1'b1, 1'b1);
    wr(GXI_REG_CFG1, 8'hFE);
    `CHK("dir", 16'hFEFF, dir_is_input)
    pin(8, 1'b0, 1'b1);
    wr(GXI_REG_CFG1, GXI_CFG_RST);
    `CHK("int", 1'b0, int_oe_n)
    gxi_master_inst.start();
    tx(GXI_GC_ADDR | 8'h01, 1'b0);
    gxi_master_inst.stop();
    gc(8'h07, 1'b0);
    gxi_master_inst.stop();
    gc(GXI_SWRST_BYTE, 1'b1);
    tx(GXI_SWRST_BYTE, 1'b0);
    gxi_master_inst.stop();
    gc(GXI_SWRST_BYTE, 1'b1);
    gxi_master_inst.start();
    gxi_master_inst.stop();
    rd(GXI_REG_MASK1, 8'hFE);
    gc(GXI_SWRST_BYTE, 1'b1);
    gxi_master_inst.stop();
    rd(GXI_REG_MASK1, GXI_MASK_RST);
    wr(GXI_REG_CFG0, 8'h00);
    @(posedge core_clk);
    reset_pin_n <= 1'b0;
    repeat (6) @(negedge core_clk);
    `CHK("dir", 16'hFFFF, dir_is_input)
    @(posedge core_clk);
    reset_pin_n <= 1'b1;
    repeat (6) @(negedge core_clk);
    rd(GXI_REG_CFG0, GXI_CFG_RST);
    print_verdict();
  end
endmodule
bind gxi_top gxi_props gxi_props_inst (.core_clk, .rst, .scl_i, .sda_i, .sda_oe_n, .reset_pin_n,
  .int_oe_n, .standby, .dir_is_input);
`default_nettype wire
